// File: src/flp_cfg.svh
// Purpose: Offsets, field positions, reset values and widths of the float LED pulse accumulator.
// Assumes: Register addresses are the 8-bit word offsets of the device register space.
// Notes:   Definitions only; included by the package and the design module.
`ifndef FLP_CFG_SVH
`define FLP_CFG_SVH

// ==========================================================================
// Register offsets
`define FLP_ADDR_LED_ROUTE      8'h14
`define FLP_ADDR_FLT_TIMING_A   8'h3E
`define FLP_ADDR_FLT_TIMING_B   8'h3F
`define FLP_ADDR_AMP_REF_A      8'h42
`define FLP_ADDR_FE_CFG_A       8'h43
`define FLP_ADDR_AMP_REF_B      8'h44
`define FLP_ADDR_FE_CFG_B       8'h45
`define FLP_ADDR_CATHODE        8'h54
`define FLP_ADDR_PULSE_MATH     8'h58
`define FLP_ADDR_FLOAT_EN_B     8'h59
`define FLP_ADDR_FIRE_PATTERN   8'h5A
`define FLP_ADDR_FLOAT_EN_A     8'h5E

// ==========================================================================
// Reset values and widths
`define FLP_REG_RESET           16'h0000
`define FLP_READ_UNMAPPED       16'h0000
`define FLP_ACC_W               24
`define FLP_ADC_W               14
`define FLP_NUM_REGS            12

// ==========================================================================
// Field positions (slot A, slot B)
`define FLP_ROUTE_A_LSB         0
`define FLP_ROUTE_B_LSB         2
`define FLP_FLOAT_EN_LSB        13
`define FLP_MATH12_A_LSB        1
`define FLP_MATH12_B_LSB        5
`define FLP_MATH34_A_LSB        8
`define FLP_MATH34_B_LSB        10
`define FLP_FIRE_A_LSB          8
`define FLP_FIRE_B_LSB          12
`define FLP_VCAT_A_LSB          8
`define FLP_VCAT_B_LSB          10
`define FLP_VCAT_OVR_BIT        7
`define FLP_DRV_SEL_LSB         14

// ==========================================================================
// Field codes
`define FLP_ROUTE_FLOAT         2'h0
`define FLP_FLOAT_EN_ON         2'h3

`endif

// File: src/flp_pkg.sv
// Purpose: Types shared by the float LED pulse accumulator and its bench.
// Assumes: flp_cfg.svh supplies widths.
// Notes:   Types only; converter and accumulator widths live in the header, state codes are set here.
`include "flp_cfg.svh"

package flp_pkg;

    // ======================================================================
    // Sequencer states
    typedef enum logic [1:0] {
        FLP_ST_IDLE  = 2'b00,
        FLP_ST_RUN   = 2'b01,
        FLP_ST_WRITE = 2'b10
    } flp_state_t;

    // ======================================================================
    // One integrated pulse result from the converter
    typedef struct packed {
        logic                      done;
        logic [`FLP_ADC_W-1:0]     result;
    } flp_pulse_t;

    // ======================================================================
    // Final sample written to the data registers or FIFO
    typedef struct packed {
        logic                      valid;
        logic                      slot;
        logic [`FLP_ACC_W-1:0]     value;
    } flp_sample_t;

    // ======================================================================
    // Per-slot view of the float LED fields
    typedef struct packed {
        logic [1:0] route;
        logic [1:0] float_en;
        logic [1:0] first_pair_sign_sel;
        logic [1:0] second_pair_sign_sel;
        logic [3:0] pulse_fire_mask;
        logic [1:0] float_led_driver_sel;
        logic [1:0] cathode_bias_sel;
    } flp_slot_cfg_t;

endpackage

// File: src/flp_accum.sv
// Purpose: Float LED synchronous measurement: LED firing pattern and signed pulse accumulation per sample.
// Assumes: Register port, timing strobes and converter results come from logic on mclk; no synchronisers needed.
// Notes:   Registers are a plain word-wide write/read port; the serial host port sits outside this block.
//
// Operation
// - In each pulse pair the LED fires in one pulse only; the code fires wherever the fire-pattern bit is zero.
// - Dark-pulse results are subtracted from lit-pulse results in the accumulator; the code takes each sign from the pair-sign codes, not from which pulse is lit.
// - Fire decision per pulse position comes from the fire-pattern register upper byte.
// - Fire and sign patterns repeat every four pulses across the whole count.
// - After all pulses, exactly one write of the final accumulated value.
// - Slot route field zero places that slot in float mode.
// - Float enable code 3 floats the photodiode between connect pulses.
// - First-pair code 2 subtracts first pulse and adds second.
// - Second-pair code 1 adds third pulse and subtracts fourth.
// - Cathode override bit set uses per-slot cathode settings instead of global.
// - Driver select code 00 drives no LED, 01 the first LED.
// - Fire-pattern bits are active low: zero fires the LED.
// - Lowest fire bit governs first pulse, highest bit the fourth.
`timescale 1ns/1ps
`include "flp_cfg.svh"

module flp_accum (
    // Clock, reset and enable
    input  wire logic                   mclk,
    input  wire logic                   arst_n,
    input  wire logic                   ce,
    // Register port
    input  wire logic [7:0]             reg_addr,
    input  wire logic [15:0]            reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic      [15:0]            reg_rdata,
    // Timing core
    input  wire logic                   sample_start,
    input  wire logic                   sample_slot,
    input  wire logic [7:0]             pulse_count_a,
    input  wire logic [7:0]             pulse_count_b,
    input  wire logic                   led_window,
    input  wire logic [1:0]             global_cathode,
    // Converter
    input  flp_pkg::flp_pulse_t         pulse_in,
    // Analog and LED controls
    output logic      [2:0]             led_drive,
    output logic                        pd_float,
    output logic      [1:0]             cathode_bias,
    // Result
    output flp_pkg::flp_sample_t        sample_out,
    output logic                        busy
);

    // ======================================================================
    // Register storage
    logic [15:0]             regs_q [`FLP_NUM_REGS];
    logic [15:0]             rdata_q;
    logic                    hit;
    logic [3:0]              idx;

    // Address decode; an unmapped address hits nothing and reads as zero.
    always_comb begin
        hit = 1'b1;
        idx = 4'h0;
        if (reg_addr == `FLP_ADDR_LED_ROUTE) begin
            idx = 4'h0;
        end else if (reg_addr == `FLP_ADDR_FLT_TIMING_A) begin
            idx = 4'h1;
        end else if (reg_addr == `FLP_ADDR_FLT_TIMING_B) begin
            idx = 4'h2;
        end else if (reg_addr == `FLP_ADDR_AMP_REF_A) begin
            idx = 4'h3;
        end else if (reg_addr == `FLP_ADDR_FE_CFG_A) begin
            idx = 4'h4;
        end else if (reg_addr == `FLP_ADDR_AMP_REF_B) begin
            idx = 4'h5;
        end else if (reg_addr == `FLP_ADDR_FE_CFG_B) begin
            idx = 4'h6;
        end else if (reg_addr == `FLP_ADDR_CATHODE) begin
            idx = 4'h7;
        end else if (reg_addr == `FLP_ADDR_PULSE_MATH) begin
            idx = 4'h8;
        end else if (reg_addr == `FLP_ADDR_FLOAT_EN_B) begin
            idx = 4'h9;
        end else if (reg_addr == `FLP_ADDR_FIRE_PATTERN) begin
            idx = 4'hA;
        end else if (reg_addr == `FLP_ADDR_FLOAT_EN_A) begin
            idx = 4'hB;
        end else begin
            hit = 1'b0;
        end
    end

    // Register writes; configuration may change mid-sample and takes effect at once.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < `FLP_NUM_REGS; i++) begin
                regs_q[i] <= `FLP_REG_RESET;
            end
        end else if (ce && reg_wr && hit) begin
            regs_q[idx] <= reg_wdata;
        end
    end

    // Read data is registered; it is valid the cycle after reg_rd.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_q <= `FLP_READ_UNMAPPED;
        end else if (ce && reg_rd) begin
            rdata_q <= hit ? regs_q[idx] : `FLP_READ_UNMAPPED;
        end
    end

    assign reg_rdata = rdata_q;

    // ======================================================================
    // Per-slot field extraction
    flp_pkg::flp_slot_cfg_t  slot_cfg [2];
    logic                    cat_ovr;

    generate
        for (genvar s = 0; s < 2; s++) begin : g_slot
            localparam int RLSB = (s == 0) ? `FLP_ROUTE_A_LSB  : `FLP_ROUTE_B_LSB;
            localparam int M1   = (s == 0) ? `FLP_MATH12_A_LSB : `FLP_MATH12_B_LSB;
            localparam int M3   = (s == 0) ? `FLP_MATH34_A_LSB : `FLP_MATH34_B_LSB;
            localparam int FLSB = (s == 0) ? `FLP_FIRE_A_LSB   : `FLP_FIRE_B_LSB;
            localparam int VLSB = (s == 0) ? `FLP_VCAT_A_LSB   : `FLP_VCAT_B_LSB;
            assign slot_cfg[s].route                = regs_q[0][RLSB+:2];
            assign slot_cfg[s].float_en             = regs_q[(s == 0) ? 11 : 9][`FLP_FLOAT_EN_LSB+:2];
            assign slot_cfg[s].first_pair_sign_sel  = regs_q[8][M1+:2];
            assign slot_cfg[s].second_pair_sign_sel = regs_q[8][M3+:2];
            assign slot_cfg[s].pulse_fire_mask      = regs_q[10][FLSB+:4];
            assign slot_cfg[s].float_led_driver_sel = regs_q[1 + s][`FLP_DRV_SEL_LSB+:2];
            assign slot_cfg[s].cathode_bias_sel     = regs_q[7][VLSB+:2];
        end
    endgenerate

    assign cat_ovr = regs_q[7][`FLP_VCAT_OVR_BIT];

    // ======================================================================
    // Sample sequencer
    flp_pkg::flp_state_t     state_q;
    logic                    slot_q;
    logic [7:0]              total_q;
    logic [7:0]              cnt_q;
    logic [1:0]              pos_q;
    logic                    start_ok;
    logic                    last_pulse;
    logic [7:0]              start_count;
    flp_pkg::flp_slot_cfg_t  cur;

    assign cur         = slot_cfg[slot_q];
    assign start_count = sample_slot ? pulse_count_b : pulse_count_a;
    // only a float-routed slot with pulses starts a sample
    assign start_ok    = (state_q == flp_pkg::FLP_ST_IDLE) && sample_start
                         && (slot_cfg[sample_slot].route == `FLP_ROUTE_FLOAT) && (start_count != 8'h00);
    assign last_pulse  = (cnt_q == total_q - 8'h01);
    assign busy        = (state_q != flp_pkg::FLP_ST_IDLE);

    // State machine: idle, accumulate the programmed count, then one write.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= flp_pkg::FLP_ST_IDLE;
        end else if (ce) begin
            case (state_q)
                flp_pkg::FLP_ST_IDLE: begin
                    if (start_ok) begin
                        state_q <= flp_pkg::FLP_ST_RUN;
                    end
                end
                flp_pkg::FLP_ST_RUN: begin
                    // write only after the last pulse
                    if (pulse_in.done && last_pulse) begin
                        state_q <= flp_pkg::FLP_ST_WRITE;
                    end
                end
                default: begin
                    state_q <= flp_pkg::FLP_ST_IDLE;
                end
            endcase
        end
    end

    // Slot and pulse total are latched at start so a reprogrammed count cannot cut a sample short.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            slot_q  <= 1'b0;
            total_q <= 8'h00;
        end else if (ce && start_ok) begin
            slot_q  <= sample_slot;
            total_q <= start_count;
        end
    end

    // Pulse counter and position within the group of four.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= 8'h00;
            pos_q <= 2'h0;
        end else if (ce) begin
            if (start_ok) begin
                cnt_q <= 8'h00;
                pos_q <= 2'h0;
            end else if (state_q == flp_pkg::FLP_ST_RUN && pulse_in.done) begin
                cnt_q <= cnt_q + 8'h01;
                pos_q <= pos_q + 2'h1;
            end
        end
    end

    // ======================================================================
    // Signed accumulation
    logic [`FLP_ACC_W-1:0]   acc_q;
    logic [`FLP_ACC_W-1:0]   term;
    logic                    negate;

    assign term = {{(`FLP_ACC_W-`FLP_ADC_W){1'b0}}, pulse_in.result};

    // pair signs: upper bit negates the earlier pulse, lower bit the later one.
    always_comb begin
        case (pos_q)
            2'h0:    negate = cur.first_pair_sign_sel[1];
            2'h1:    negate = cur.first_pair_sign_sel[0];
            2'h2:    negate = cur.second_pair_sign_sel[1];
            default: negate = cur.second_pair_sign_sel[0];
        endcase
    end

    // Wraps silently on overflow; the width covers 255 full-scale pulses.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            acc_q <= '0;
        end else if (ce) begin
            if (start_ok) begin
                acc_q <= '0;
            end else if (state_q == flp_pkg::FLP_ST_RUN && pulse_in.done) begin
                acc_q <= negate ? acc_q - term : acc_q + term;
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            sample_out <= '0;
        end else if (ce) begin
            sample_out.valid <= (state_q == flp_pkg::FLP_ST_WRITE);
            if (state_q == flp_pkg::FLP_ST_WRITE) begin
                sample_out.slot  <= slot_q;
                sample_out.value <= acc_q;
            end
        end
    end

    // ======================================================================
    // LED, float and cathode controls
    logic                    fire_now;
    logic [2:0]              drv_onehot;

    assign fire_now = ~cur.pulse_fire_mask[pos_q];

    always_comb begin
        case (cur.float_led_driver_sel)
            2'h0:    drv_onehot = 3'h0;
            2'h1:    drv_onehot = 3'h1;
            2'h2:    drv_onehot = 3'h2;
            default: drv_onehot = 3'h4;
        endcase
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            led_drive <= 3'h0;
        end else if (ce) begin
            led_drive <= (state_q == flp_pkg::FLP_ST_RUN && led_window && fire_now) ? drv_onehot : 3'h0;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            pd_float <= 1'b0;
        end else if (ce) begin
            pd_float <= (state_q == flp_pkg::FLP_ST_RUN) && (cur.float_en == `FLP_FLOAT_EN_ON);
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cathode_bias <= 2'h0;
        end else if (ce) begin
            cathode_bias <= cat_ovr ? cur.cathode_bias_sel : global_cathode;
        end
    end

    // ======================================================================
    // Assertions
    clear_on_start_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (ce && start_ok) |=> (acc_q == '0))
        else $error("Accumulator not cleared at sample start.");

    single_write_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (ce && state_q == flp_pkg::FLP_ST_RUN && pulse_in.done && last_pulse) |=> ce [*1] ##1 sample_out.valid)
        else $error("Final value not written after last pulse.");

    write_once_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (ce && sample_out.valid) |=> !sample_out.valid)
        else $error("Result written twice for one sample.");

    float_route_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (ce && state_q == flp_pkg::FLP_ST_IDLE && slot_cfg[sample_slot].route != `FLP_ROUTE_FLOAT)
        |=> (state_q == flp_pkg::FLP_ST_IDLE))
        else $error("Sample started on a slot not in float mode.");

    group_wrap_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (ce && state_q == flp_pkg::FLP_ST_RUN && pulse_in.done && pos_q == 2'h3 && !last_pulse)
        |=> (pos_q == 2'h0))
        else $error("Pulse position did not wrap after four pulses.");

    first_sub_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (ce && state_q == flp_pkg::FLP_ST_RUN && pulse_in.done && pos_q == 2'h0
         && cur.first_pair_sign_sel == 2'h2)
        |=> (acc_q == $past(acc_q) - $past(term)))
        else $error("First pulse not subtracted for pair code 2.");

    fourth_sub_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (ce && state_q == flp_pkg::FLP_ST_RUN && pulse_in.done && pos_q == 2'h3
         && cur.second_pair_sign_sel == 2'h1)
        |=> (acc_q == $past(acc_q) - $past(term)))
        else $error("Fourth pulse not subtracted for pair code 1.");

    dark_pulse_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (ce && cur.pulse_fire_mask[pos_q]) |=> (led_drive == 3'h0))
        else $error("LED fired in a position whose mask bit is one.");

    no_led_sel_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (ce && cur.float_led_driver_sel == 2'h0) |=> (led_drive == 3'h0))
        else $error("LED driven with driver select zero.");

    third_drv_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (ce && state_q == flp_pkg::FLP_ST_RUN && led_window && fire_now
         && cur.float_led_driver_sel == 2'h3) |=> (led_drive == 3'h4))
        else $error("Driver code 3 did not select the third LED.");

    float_en_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (ce && state_q == flp_pkg::FLP_ST_RUN && cur.float_en == `FLP_FLOAT_EN_ON) |=> pd_float)
        else $error("Photodiode not floated with enable code 3.");

    cathode_ovr_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (ce && cat_ovr) |=> (cathode_bias == $past(cur.cathode_bias_sel)))
        else $error("Override did not select per-slot cathode setting.");

endmodule

// File: verif/flp_sensor_model.sv
// Purpose: Behavioural LED and photodiode model that returns one integrated result per pulse.
// Assumes: The bench marks the end of each pulse with pulse_end, one cycle after the LED window.
// Notes:   Between results the result bus changes every cycle so stale data is never mistaken for a result.
`timescale 1ns/1ps

// ==========================================================================
// Sensor model
module flp_sensor_model #(
    parameter logic [13:0] AMBIENT  = 14'h0064,
    parameter logic [13:0] LED_GAIN = 14'h0032
) (
    // Clock and reset
    input  wire logic            mclk,
    input  wire logic            arst_n,
    // Pulse timing from the bench
    input  wire logic            pulse_end,
    input  wire logic            clr_seen,
    // LED drivers from the device
    input  wire logic [2:0]      led_drive,
    // Integrated results and driver history
    output flp_pkg::flp_pulse_t  pulse_in,
    output logic      [2:0]      led_seen
);
    logic lit_q;

    // Light collects while any driver is on; the result goes out when the pulse ends.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            lit_q    <= 1'b0;
            pulse_in <= '0;
            led_seen <= 3'h0;
        end else begin
            pulse_in.done   <= pulse_end;
            // a lit pulse carries return plus ambient, a dark pulse ambient alone.
            pulse_in.result <= pulse_end ? (AMBIENT + (lit_q ? LED_GAIN : 14'h0000)) : ~pulse_in.result;
            lit_q           <= pulse_end ? 1'b0 : (lit_q | (|led_drive));
            led_seen        <= clr_seen ? 3'h0 : (led_seen | led_drive);
        end
    end
endmodule

// File: verif/float_led_pulse_accumulator_tb_top.sv
// Purpose: Self-checking bench for the float LED pulse accumulator.
// Assumes: Model returns 0x64 per pulse plus 0x32 when lit, so each lit pair nets 0x32.
// Notes:   Register readback first, then table rows, slot B, cathode choice, a refused start and a reset mid-sample.
`timescale 1ns/1ps

// ==========================================================================
// Bench top
module float_led_pulse_accumulator_tb_top;
    typedef struct packed {
        logic [1:0]  sel;
        logic [3:0]  mask;
        logic [1:0]  m12;
        logic [1:0]  m34;
        logic [7:0]  cnt;
        logic [23:0] val;
        logic [2:0]  led;
    } flp_row_t;

    logic                  mclk = 1'b0;
    logic                  arst_n = 1'b0;
    logic                  ce = 1'b1;
    logic [7:0]            reg_addr = 8'h00;
    logic [15:0]           reg_wdata = 16'h0000;
    logic                  reg_wr = 1'b0;
    logic                  reg_rd = 1'b0;
    logic                  sample_start = 1'b0;
    logic                  sample_slot = 1'b0;
    logic [7:0]            pulse_count_a = 8'h00;
    logic [7:0]            pulse_count_b = 8'h00;
    logic                  led_window = 1'b0;
    logic [1:0]            global_cathode = 2'h1;
    logic                  pulse_end = 1'b0;
    logic                  clr_seen = 1'b0;
    logic [15:0]           reg_rdata;
    logic [2:0]            led_drive;
    logic [2:0]            led_seen;
    logic [1:0]            cathode_bias;
    logic                  pd_float;
    logic                  busy;
    flp_pkg::flp_pulse_t   pulse_in;
    flp_pkg::flp_sample_t  sample_out;
    int                    n_mismatch = 0;
    int                    tests_run = 0;
    int                    n_valid = 0;
    // Every driver code, first-pair codes 1-3 and second-pair codes 0-2 appear; rows run back to back so a stale sum shows.
    flp_row_t              rows [6] = '{
        '{2'h1, 4'h9, 2'h2, 2'h1, 8'h04, 24'h000064, 3'h1},
        '{2'h2, 4'h9, 2'h2, 2'h1, 8'h08, 24'h0000C8, 3'h2},
        '{2'h3, 4'h6, 2'h2, 2'h1, 8'h04, 24'hFFFF9C, 3'h4},
        '{2'h0, 4'h9, 2'h2, 2'h1, 8'h04, 24'h000000, 3'h0},
        '{2'h1, 4'h9, 2'h1, 2'h2, 8'h04, 24'hFFFF9C, 3'h1},
        '{2'h1, 4'h9, 2'h3, 2'h0, 8'h04, 24'h000000, 3'h1}};
    logic [7:0]            cfg_a [9] = '{8'h14, 8'h5E, 8'h59, 8'h43, 8'h45, 8'h42, 8'h44, 8'h54, 8'h01};
    logic [15:0]           cfg_d [9] = '{16'h0000, 16'h6000, 16'h6000, 16'hAE65, 16'hAE65,
                                         16'h0020, 16'h0020, 16'h0A80, 16'h1234};

    flp_accum flp_accum_inst (
        .mclk(mclk), .arst_n(arst_n), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_start(sample_start),
        .sample_slot(sample_slot), .pulse_count_a(pulse_count_a), .pulse_count_b(pulse_count_b),
        .led_window(led_window), .global_cathode(global_cathode), .pulse_in(pulse_in),
        .led_drive(led_drive), .pd_float(pd_float), .cathode_bias(cathode_bias),
        .sample_out(sample_out), .busy(busy));

    flp_sensor_model flp_sensor_model_inst (
        .mclk(mclk), .arst_n(arst_n), .pulse_end(pulse_end), .clr_seen(clr_seen),
        .led_drive(led_drive), .pulse_in(pulse_in), .led_seen(led_seen));

    // Free-running clock and a count of result writes.
    always #2.5 mclk = ~mclk;
    always @(posedge mclk) if (sample_out.valid === 1'b1) n_valid++;

    task automatic tally_and_finish();
        $display("checks run %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    // Each access leaves an idle cycle so a strobe is never dropped and raised in one step.
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge mclk);
        reg_wr = 1'b0;
        @(negedge mclk);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [15:0] d);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge mclk);
        reg_rd = 1'b0;
        @(negedge mclk);
        chk({8'h00, reg_rdata}, {8'h00, d});
    endtask

    // One sample: start, then per pulse a two-cycle LED window and an end mark.
    task automatic run_sample(input logic s, input logic [23:0] v, input logic [2:0] led, input logic [1:0] cath);
        int k;
        logic [7:0] cnt;
        cnt = s ? pulse_count_b : pulse_count_a;
        n_valid = 0;
        sample_slot = s;
        sample_start = 1'b1;
        clr_seen = 1'b1;
        @(negedge mclk);
        sample_start = 1'b0;
        clr_seen = 1'b0;
        for (k = 0; k < cnt; k++) begin
            led_window = 1'b1;
            repeat (2) @(negedge mclk);
            led_window = 1'b0;
            chk({pd_float, cathode_bias}, {1'b1, cath});
            @(negedge mclk);
            pulse_end = 1'b1;
            @(negedge mclk);
            pulse_end = 1'b0;
            @(negedge mclk);
        end
        for (k = 0; k < 20 && sample_out.valid !== 1'b1; k++) @(negedge mclk);
        if (k == 20) begin
            n_mismatch++;
            tally_and_finish();
        end
        chk(sample_out.value, v);
        chk({busy, sample_out.slot, led_seen}, {1'b0, s, led});
        repeat (4) @(negedge mclk);
        chk(n_valid, 24'h000001);
    endtask

    // ======================================================================
    // Main sequence
    initial begin
        repeat (6) @(negedge mclk);
        arst_n = 1'b1;
        @(negedge mclk);
        rd_chk(8'h58, 16'h0000);
        // float mode, float enable, front end, reference and cathode setup.
        for (int i = 0; i < 9; i++) wr(cfg_a[i], cfg_d[i]);
        for (int i = 0; i < 9; i++) rd_chk(cfg_a[i], (i == 8) ? 16'h0000 : cfg_d[i]);
        // even counts; the recommended lit-middle pattern heads the table.
        foreach (rows[i]) begin
            wr(8'h3E, {rows[i].sel, 14'h0000});
            wr(8'h5A, {4'h0, rows[i].mask, 8'h00});
            wr(8'h58, {6'h00, rows[i].m34, 5'h00, rows[i].m12, 1'b0});
            pulse_count_a = rows[i].cnt;
            run_sample(1'b0, rows[i].val, rows[i].led, 2'h2);
        end
        wr(8'h3F, 16'h4000);
        wr(8'h5A, 16'h9000);
        wr(8'h58, 16'h0440);
        pulse_count_b = 8'h04;
        run_sample(1'b1, 24'h000064, 3'h1, 2'h2);
        // With the override clear the global code applies; minimum count of two.
        wr(8'h54, 16'h0A00);
        pulse_count_b = 8'h02;
        run_sample(1'b1, 24'h000032, 3'h1, 2'h1);
        // A slot that is not in float mode ignores its start.
        wr(8'h14, 16'h0004);
        sample_slot = 1'b1;
        sample_start = 1'b1;
        @(negedge mclk);
        chk(busy, 1'b0);
        // Reset in mid-sample clears the sequencer and the registers; the start strobe is dropped before reset.
        sample_slot = 1'b0;
        @(negedge mclk);
        sample_start = 1'b0;
        chk(busy, 1'b1);
        arst_n = 1'b0;
        @(negedge mclk);
        chk({busy, led_drive, sample_out.valid, sample_out.slot}, 24'h000000);
        chk(sample_out.value, 24'h000000);
        arst_n = 1'b1;
        @(negedge mclk);
        rd_chk(8'h14, 16'h0000);
        tally_and_finish();
    end
endmodule
